// ===== core/lpm_pkg.sv
// package: shared types and constants of the lvds pixel lane mapper
package lpm_pkg;
    // mapping option codes, as selected by software
    typedef enum logic [1:0] {
        LPM_OPT_ONE   = 2'b00,
        LPM_OPT_TWO   = 2'b01,
        LPM_OPT_THREE = 2'b10,
        LPM_OPT_FOUR  = 2'b11
    } lpm_opt_t;

    localparam int LPM_LANE_W = 7;
    localparam int LPM_COLOR_W = 10;
    // lane c control bit positions
    localparam int LPM_C_DE_BIT = 6;
    localparam int LPM_C_VS_BIT = 5;
    localparam int LPM_C_HS_BIT = 4;
    // lane d / lane e field bit position
    localparam int LPM_FIELD_BIT = 6;
    // start-up limit: time in its own unit, cycles derived from the clock rate
    localparam int LPM_CLOCK_MHZ = 250;
    localparam int LPM_STARTUP_US = 1000;
    localparam int LPM_STARTUP_CYCLES = LPM_STARTUP_US * LPM_CLOCK_MHZ;
    localparam int LPM_WAIT_W = 18;
    localparam logic [LPM_COLOR_W-1:0] LPM_COLOR_RST = 10'h000;

    // everything that arrives from the link side, synchronised as one bundle
    typedef struct packed {
        logic clk;
        lpm_opt_t opt;
        logic [LPM_LANE_W-1:0] e;
        logic [LPM_LANE_W-1:0] d;
        logic [LPM_LANE_W-1:0] c;
        logic [LPM_LANE_W-1:0] b;
        logic [LPM_LANE_W-1:0] a;
    } lpm_bundle_t;

    typedef struct packed {
        lpm_bundle_t meta1;
        lpm_bundle_t meta2;
        logic clk_prev;
        logic [LPM_COLOR_W-1:0] red;
        logic [LPM_COLOR_W-1:0] green;
        logic [LPM_COLOR_W-1:0] blue;
        logic de;
        logic vs;
        logic hs;
        logic field_one;
        logic field_two;
        logic ready;
        logic late;
        logic [LPM_WAIT_W-1:0] wait_cnt;
    } lpm_state_t;
endpackage

// ===== core/lpm_lane_map.sv
// module: combinational lane-to-colour mapping for the four options
`timescale 1ns/1ns
`default_nettype none
module lpm_lane_map
    import lpm_pkg::*;
(
    input wire lpm_opt_t i_opt,
    input wire logic [LPM_LANE_W-1:0] i_lane_a_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_b_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_c_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_d_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_e_word,
    output logic [LPM_COLOR_W-1:0] o_red,
    output logic [LPM_COLOR_W-1:0] o_green_component,
    output logic [LPM_COLOR_W-1:0] o_blue_component
);
    // unmapped colour bits stay zero in every option
    always_comb begin
        o_red = LPM_COLOR_RST; // see (RL10)
        o_green_component = LPM_COLOR_RST;
        o_blue_component = LPM_COLOR_RST;
        case (i_opt) // see (RL1)
            LPM_OPT_TWO: begin
                o_green_component[2] = i_lane_a_word[6]; // see (RL2)
                o_red[7:2] = i_lane_a_word[5:0];
                o_blue_component[3:2] = i_lane_b_word[6:5]; // see (RL3)
                o_green_component[7:3] = i_lane_b_word[4:0];
                o_blue_component[7:4] = i_lane_c_word[3:0]; // see (RL4)
                o_blue_component[9:8] = i_lane_d_word[5:4]; // see (RL6)
                o_green_component[9:8] = i_lane_d_word[3:2];
                o_red[9:8] = i_lane_d_word[1:0];
                // lane e colour is left unused here; see (RL10)
            end
            LPM_OPT_THREE: begin
                o_green_component[0] = i_lane_a_word[6]; // see (RL2)
                o_red[5:0] = i_lane_a_word[5:0];
                o_blue_component[1:0] = i_lane_b_word[6:5]; // see (RL3)
                o_green_component[5:1] = i_lane_b_word[4:0];
                o_blue_component[5:2] = i_lane_c_word[3:0]; // see (RL4)
                o_blue_component[7:6] = i_lane_d_word[5:4]; // see (RL6)
                o_green_component[7:6] = i_lane_d_word[3:2];
                o_red[7:6] = i_lane_d_word[1:0];
                o_blue_component[9:8] = i_lane_e_word[5:4]; // see (RL9)
                o_green_component[9:8] = i_lane_e_word[3:2];
                o_red[9:8] = i_lane_e_word[1:0];
            end
            default: begin
                // options one and four share lanes a to c
                o_green_component[4] = i_lane_a_word[6]; // see (RL2)
                o_red[9:4] = i_lane_a_word[5:0];
                o_blue_component[5:4] = i_lane_b_word[6:5]; // see (RL3)
                o_green_component[9:5] = i_lane_b_word[4:0];
                o_blue_component[9:6] = i_lane_c_word[3:0]; // see (RL4)
                // 18-bit option ignores lanes d and e colour bits
                if (i_opt == LPM_OPT_ONE) begin // see (RL7)
                    o_blue_component[3:2] = i_lane_d_word[5:4]; // see (RL6)
                    o_green_component[3:2] = i_lane_d_word[3:2];
                    o_red[3:2] = i_lane_d_word[1:0];
                    o_blue_component[1:0] = i_lane_e_word[5:4]; // see (RL9)
                    o_green_component[1:0] = i_lane_e_word[3:2];
                    o_red[1:0] = i_lane_e_word[1:0];
                end
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== core/lpm_top.sv
// module: lvds pixel lane mapper, samples the recovered link words and maps them
// Contract
// (RL1) four mapping options, chosen by software setting
// (RL2) lane a feeds green and red per option
// (RL3) lane b feeds blue and green per option
// (RL4) lane c low nibble feeds blue
// (RL5) lane c bits 6,5,4: enable, vsync, hsync
// (RL6) lane d feeds low or high colour bits
// (RL7) option four ignores lanes d and e colour
// (RL8) lane d/e bit 6 are field flags
// (RL9) lane e feeds colour in options one, three
// (RL10) unused colour bits driven to zero
// (RL11) all pixel outputs registered in same cycle
// (RL12) mapped output valid within one millisecond
`timescale 1ns/1ns
`default_nettype none
module lpm_top
    import lpm_pkg::*;
#(
    parameter int STARTUP_CYCLES = LPM_STARTUP_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_link_pixel_clock,
    input wire lpm_opt_t i_map_option,
    input wire logic [LPM_LANE_W-1:0] i_lane_a_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_b_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_c_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_d_word,
    input wire logic [LPM_LANE_W-1:0] i_lane_e_word,
    output logic [LPM_COLOR_W-1:0] o_red,
    output logic [LPM_COLOR_W-1:0] o_green_component,
    output logic [LPM_COLOR_W-1:0] o_blue_component,
    output logic o_pixel_valid_flag,
    output logic o_vsync,
    output logic o_hsync,
    output logic o_field_one,
    output logic o_field_two,
    output logic o_link_ready,
    output logic o_startup_late
);
    localparam logic [LPM_WAIT_W-1:0] WAIT_LIMIT = LPM_WAIT_W'(STARTUP_CYCLES);

    lpm_state_t s;
    lpm_state_t next_s;
    lpm_bundle_t raw;
    logic cap;
    logic [LPM_COLOR_W-1:0] map_red;
    logic [LPM_COLOR_W-1:0] map_green;
    logic [LPM_COLOR_W-1:0] map_blue;

    // the whole link side crosses as one bundle through two flops;
    // data is assumed stable around the rising link edge, so the
    // clock and words see the same synchroniser delay
    assign raw = '{clk: i_link_pixel_clock, opt: i_map_option, e: i_lane_e_word,
                   d: i_lane_d_word, c: i_lane_c_word, b: i_lane_b_word,
                   a: i_lane_a_word};
    // rising link edge seen on the second stage only
    assign cap = s.meta2.clk && !s.clk_prev;

    lpm_lane_map u_map (
        .i_opt(s.meta2.opt),
        .i_lane_a_word(s.meta2.a),
        .i_lane_b_word(s.meta2.b),
        .i_lane_c_word(s.meta2.c),
        .i_lane_d_word(s.meta2.d),
        .i_lane_e_word(s.meta2.e),
        .o_red(map_red),
        .o_green_component(map_green),
        .o_blue_component(map_blue)
    );

    // next-state: synchronise, capture a whole pixel on each link edge
    always_comb begin
        next_s = s;
        next_s.meta1 = raw;
        next_s.meta2 = s.meta1;
        next_s.clk_prev = s.meta2.clk;
        if (cap) begin
            // all pixel bits load together; see (RL11)
            next_s.red = map_red;
            next_s.green = map_green;
            next_s.blue = map_blue;
            next_s.de = s.meta2.c[LPM_C_DE_BIT]; // see (RL5)
            next_s.vs = s.meta2.c[LPM_C_VS_BIT];
            next_s.hs = s.meta2.c[LPM_C_HS_BIT];
            next_s.field_one = s.meta2.d[LPM_FIELD_BIT]; // see (RL8)
            next_s.field_two = s.meta2.e[LPM_FIELD_BIT];
            next_s.ready = 1'b1; // see (RL12)
        end
        // start-up watchdog: flags a link that never delivered a pixel
        if (!s.ready && !cap) begin
            if (s.wait_cnt >= WAIT_LIMIT) begin
                next_s.late = 1'b1; // see (RL12)
            end else begin
                next_s.wait_cnt = s.wait_cnt + LPM_WAIT_W'(1);
            end
        end
    end

    // state register, synchronous reset to constants only
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign o_red = s.red;
    assign o_green_component = s.green;
    assign o_blue_component = s.blue;
    assign o_pixel_valid_flag = s.de;
    assign o_vsync = s.vs;
    assign o_hsync = s.hs;
    assign o_field_one = s.field_one;
    assign o_field_two = s.field_two;
    assign o_link_ready = s.ready;
    assign o_startup_late = s.late;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    sequence cap_opt(lpm_opt_t o);
        cap && s.meta2.opt == o;
    endsequence

    chk_sync_controls: assert property ( // see (RL5)
        cap |=> o_pixel_valid_flag == $past(s.meta2.c[6]) && o_vsync == $past(s.meta2.c[5])
            && o_hsync == $past(s.meta2.c[4]))
        else $error("sync controls not taken from lane c");
    chk_lane_a_opt1: assert property ( // see (RL2)
        cap_opt(LPM_OPT_ONE) |=> o_red[9:4] == $past(s.meta2.a[5:0])
            && o_green_component[4] == $past(s.meta2.a[6]))
        else $error("lane a wrong in option one");
    chk_lane_b_opt2: assert property ( // see (RL3)
        cap_opt(LPM_OPT_TWO) |=> o_green_component[7:3] == $past(s.meta2.b[4:0])
            && o_blue_component[3:2] == $past(s.meta2.b[6:5]))
        else $error("lane b wrong in option two");
    chk_lane_c_opt3: assert property ( // see (RL4)
        cap_opt(LPM_OPT_THREE) |=> o_blue_component[5:2] == $past(s.meta2.c[3:0]))
        else $error("lane c wrong in option three");
    chk_lane_d_opt1: assert property ( // see (RL6)
        cap_opt(LPM_OPT_ONE) |=> o_blue_component[3:2] == $past(s.meta2.d[5:4])
            && o_red[3:2] == $past(s.meta2.d[1:0]))
        else $error("lane d wrong in option one");
    chk_opt4_ignores: assert property ( // see (RL7)
        cap_opt(LPM_OPT_FOUR) |=> o_red[3:0] == 4'h0 && o_blue_component[3:0] == 4'h0
            && o_green_component[3:0] == 4'h0)
        else $error("option four drove low colour bits");
    chk_field_flags: assert property ( // see (RL8)
        cap |=> o_field_one == $past(s.meta2.d[6]) && o_field_two == $past(s.meta2.e[6]))
        else $error("field flags not taken from lanes d and e");
    chk_lane_e_opt3: assert property ( // see (RL9)
        cap_opt(LPM_OPT_THREE) |=> o_red[9:8] == $past(s.meta2.e[1:0])
            && o_blue_component[9:8] == $past(s.meta2.e[5:4]))
        else $error("lane e wrong in option three");
    chk_opt2_zeros: assert property ( // see (RL10)
        cap_opt(LPM_OPT_TWO) |=> o_red[1:0] == 2'h0 && o_green_component[1:0] == 2'h0
            && o_blue_component[1:0] == 2'h0)
        else $error("option two low bits not zero");
    chk_pixel_hold: assert property ( // see (RL11)
        !cap |=> $stable(o_red) && $stable(o_blue_component) && $stable(o_pixel_valid_flag))
        else $error("pixel changed without a link edge");
    chk_ready_first: assert property ( // see (RL12)
        cap |=> o_link_ready ##1 o_link_ready)
        else $error("ready not held after first pixel");

    // remaining lane placements except lane c in option one, one property per lane and option
    chk_lane_a_opt2: assert property ( // see (RL2)
        cap_opt(LPM_OPT_TWO) |=> o_red[7:2] == $past(s.meta2.a[5:0])
            && o_green_component[2] == $past(s.meta2.a[6]))
        else $error("lane a wrong in option two");
    chk_lane_a_opt3: assert property ( // see (RL2)
        cap_opt(LPM_OPT_THREE) |=> o_red[5:0] == $past(s.meta2.a[5:0])
            && o_green_component[0] == $past(s.meta2.a[6]))
        else $error("lane a wrong in option three");
    chk_lane_b_opt1: assert property ( // see (RL3)
        cap_opt(LPM_OPT_ONE) |=> o_green_component[9:5] == $past(s.meta2.b[4:0])
            && o_blue_component[5:4] == $past(s.meta2.b[6:5]))
        else $error("lane b wrong in option one");
    chk_lane_b_opt3: assert property ( // see (RL3)
        cap_opt(LPM_OPT_THREE) |=> o_green_component[5:1] == $past(s.meta2.b[4:0])
            && o_blue_component[1:0] == $past(s.meta2.b[6:5]))
        else $error("lane b wrong in option three");
    chk_lane_c_opt2: assert property ( // see (RL4)
        cap_opt(LPM_OPT_TWO) |=> o_blue_component[7:4] == $past(s.meta2.c[3:0]))
        else $error("lane c wrong in option two");

    // option four must still carry lane a bits 5:0, lane b bits 4:0 and lane c bits 3:0 as option one does
    chk_opt4_upper: assert property ( // see (RL7)
        cap_opt(LPM_OPT_FOUR) |=> o_red[9:4] == $past(s.meta2.a[5:0])
            && o_green_component[9:5] == $past(s.meta2.b[4:0])
            && o_blue_component[9:6] == $past(s.meta2.c[3:0]))
        else $error("option four lost lanes a to c");
    chk_lane_d_opt2: assert property ( // see (RL6)
        cap_opt(LPM_OPT_TWO) |=> o_red[9:8] == $past(s.meta2.d[1:0])
            && o_green_component[9:8] == $past(s.meta2.d[3:2])
            && o_blue_component[9:8] == $past(s.meta2.d[5:4]))
        else $error("lane d wrong in option two");
    chk_lane_d_opt3: assert property ( // see (RL6)
        cap_opt(LPM_OPT_THREE) |=> o_red[7:6] == $past(s.meta2.d[1:0])
            && o_green_component[7:6] == $past(s.meta2.d[3:2])
            && o_blue_component[7:6] == $past(s.meta2.d[5:4]))
        else $error("lane d wrong in option three");
    chk_lane_e_opt1: assert property ( // see (RL9)
        cap_opt(LPM_OPT_ONE) |=> o_red[1:0] == $past(s.meta2.e[1:0])
            && o_green_component[1:0] == $past(s.meta2.e[3:2])
            && o_blue_component[1:0] == $past(s.meta2.e[5:4]))
        else $error("lane e wrong in option one");

    // the rest of the pixel must hold between link edges as well
    chk_pixel_hold_rest: assert property ( // see (RL11)
        !cap |=> $stable(o_green_component) && $stable(o_vsync) && $stable(o_hsync)
            && $stable(o_field_one) && $stable(o_field_two))
        else $error("pixel controls changed without a link edge");
    // the late flag is sticky, and a link that delivered in time never raises it
    chk_late_sticky: assert property ( // see (RL12)
        o_startup_late |=> o_startup_late)
        else $error("start-up late flag dropped");
    chk_late_after_ready: assert property ( // see (RL12)
        o_link_ready && !o_startup_late |=> !o_startup_late)
        else $error("late flag raised after first pixel");
endmodule
`default_nettype wire

// ===== verification/lpm_tx_model.sv
// file: behavioural model of the video transmitter that drives the link
`timescale 1ns/1ns
`default_nettype none
module lpm_tx_model
    import lpm_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_run,
    input wire lpm_opt_t i_opt,
    input wire logic [34:0] i_words,
    output logic o_link_clk,
    output lpm_opt_t o_opt,
    output logic [34:0] o_words,
    output logic o_load
);
    logic [3:0] ph;
    initial begin
        ph = 4'h0;
        o_link_clk = 1'b0;
        o_opt = LPM_OPT_ONE;
        o_words = 35'h0;
        o_load = 1'b0;
    end
    // 16 system cycles per pixel (64 ns); words change while the link clock is low
    always @(posedge i_clock) begin
        if (!i_run) begin
            ph <= 4'h0;
            o_link_clk <= 1'b0; // clock stands still between frames
            o_words <= ~o_words; // released lanes: do not keep showing the last word
            o_load <= 1'b0;
        end else begin
            ph <= ph + 4'h1;
            o_link_clk <= ph[3];
            o_load <= (ph == 4'h0);
            if (ph == 4'h0) begin
                o_words <= i_words;
                o_opt <= i_opt;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// file: self-checking testbench of the lane mapper
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import lpm_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic run = 1'b0;
    lpm_opt_t opt_next = LPM_OPT_ONE;
    logic [34:0] words_next = 35'h0;
    logic link_clk, tx_load, de, vs, hs, f1, f2, ready, late;
    lpm_opt_t tx_opt;
    logic [34:0] tx_words;
    logic [9:0] red, green, blue;
    logic [34:0] expq[$];
    logic [34:0] ex;
    int num_errors = 0;
    int compares = 0;
    integer seed = 32'h1C21;
    always #2 i_clock = ~i_clock;
    lpm_tx_model u_tx (.i_clock(i_clock), .i_run(run), .i_opt(opt_next), .i_words(words_next),
        .o_link_clk(link_clk), .o_opt(tx_opt), .o_words(tx_words), .o_load(tx_load));
    // short start-up limit keeps the late-link case quick
    lpm_top #(.STARTUP_CYCLES(50)) u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_link_pixel_clock(link_clk), .i_map_option(tx_opt),
        .i_lane_a_word(tx_words[6:0]), .i_lane_b_word(tx_words[13:7]),
        .i_lane_c_word(tx_words[20:14]), .i_lane_d_word(tx_words[27:21]),
        .i_lane_e_word(tx_words[34:28]), .o_red(red), .o_green_component(green),
        .o_blue_component(blue), .o_pixel_valid_flag(de), .o_vsync(vs), .o_hsync(hs),
        .o_field_one(f1), .o_field_two(f2), .o_link_ready(ready), .o_startup_late(late));
    task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // reference mapping: {red, green, blue, enable, vsync, hsync, field one, field two}
    function logic [34:0] ref_pixel(input lpm_opt_t o, input logic [34:0] w);
        logic [6:0] a, b, c, d, e;
        logic [9:0] r, g, bl;
        a = w[6:0];
        b = w[13:7];
        c = w[20:14];
        d = w[27:21];
        e = w[34:28];
        r = {a[5:0], d[1:0], e[1:0]};
        g = {b[4:0], a[6], d[3:2], e[3:2]};
        bl = {c[3:0], b[6:5], d[5:4], e[5:4]};
        if (o == LPM_OPT_TWO) begin
            r = {d[1:0], a[5:0], 2'h0};
            g = {d[3:2], b[4:0], a[6], 2'h0};
            bl = {d[5:4], c[3:0], b[6:5], 2'h0};
        end else if (o == LPM_OPT_THREE) begin
            r = {e[1:0], d[1:0], a[5:0]};
            g = {e[3:2], d[3:2], b[4:0], a[6]};
            bl = {e[5:4], d[5:4], c[3:0], b[6:5]};
        end else if (o == LPM_OPT_FOUR) begin
            r[3:0] = 4'h0;
            g[3:0] = 4'h0;
            bl[3:0] = 4'h0;
        end
        return {r, g, bl, c[6], c[5], c[4], d[6], e[6]};
    endfunction
    // one pixel: wait for the transmitter to launch it, queue the reference, compare later
    task pixel(input int i);
        int n;
        n = 0;
        while (tx_load !== 1'b1 && n < 40) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (n >= 40) begin
            num_errors++;
            results();
        end
        expq.push_back(ref_pixel(tx_opt, tx_words));
        @(posedge i_clock);
        opt_next <= (i < 8) ? lpm_opt_t'(i[1:0]) : lpm_opt_t'(2'($random(seed)));
        words_next <= (i < 4) ? 35'h7_FFFF_FFFF : 35'({$random(seed), $random(seed)});
        repeat (13) @(posedge i_clock);
        #1;
        ex = expq.pop_front();
        check("red", 40'(red), 40'(ex[34:25]));
        check("green", 40'(green), 40'(ex[24:15]));
        check("blue", 40'(blue), 40'(ex[14:5]));
        check("flags", 40'({de, vs, hs, f1, f2}), 40'(ex[4:0]));
        check("status", 40'({ready, late}), 40'h2);
    endtask
    initial begin
        repeat (6) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        check("idle outputs", 40'({red, green, blue, de, vs, hs, f1, f2, ready}), 40'h0);
        // link never starts: the start-up limit must be flagged
        repeat (60) @(posedge i_clock);
        #1;
        check("late flag", 40'({ready, late}), 40'h1);
        @(posedge i_clock);
        i_sys_rst <= 1'b1;
        words_next <= 35'h7_FFFF_FFFF;
        repeat (6) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        run <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            pixel(i);
        end
        results();
    end
endmodule
`default_nettype wire
